// File: rtl/npio_pkg.sv
package npio_pkg;

	// register indices; byte address is four times the index
	localparam logic [13:0] IDX_DIR_LOW    = 14'h2004;
	localparam logic [13:0] IDX_DATA_LOW   = 14'h2005;
	localparam logic [13:0] IDX_EN_LOW     = 14'h2006;
	localparam logic [13:0] IDX_FLAGS_LOW  = 14'h2007;
	localparam logic [13:0] IDX_DIR_NINTH  = 14'h2044;
	localparam logic [13:0] IDX_DATA_NINTH = 14'h2045;
	localparam logic [13:0] IDX_EN_NINTH   = 14'h2046;
	localparam logic [13:0] IDX_FLAGS_NINTH = 14'h2047;
	localparam logic [13:0] IDX_SELECT     = 14'h2049;
	localparam logic [13:0] IDX_IRQ_STATUS = 14'h2050;
	localparam logic [13:0] IDX_IRQ_MASK   = 14'h2051;

	// field layout
	localparam int NUM_LINES      = 9;
	localparam int NUM_LOW        = 8;
	localparam int NINTH_DATA_BIT = 0;
	localparam int NINTH_SEL_BIT  = 1;

	// reset values
	localparam logic [7:0] SELECT_RESET    = 8'hff;
	localparam logic       NINTH_SEL_RESET = 1'h1;
	localparam logic [8:0] DIR_RESET       = 9'h000;
	localparam logic [8:0] DATA_RESET      = 9'h000;
	localparam logic [8:0] EN_RESET        = 9'h000;
	localparam logic [8:0] FLAGS_RESET     = 9'h000;
	localparam logic [8:0] STATUS_RESET    = 9'h000;
	localparam logic [8:0] MASK_RESET      = 9'h000;

	// synchroniser depth ahead of edge detection
	localparam int SYNC_STAGES = 2;

endpackage

// File: rtl/npio_sync.sv
`timescale 1ns/1ps
module npio_sync (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic [8:0] pin_in,
	output logic      [8:0] level,
	output logic      [8:0] change
);

	typedef struct packed {
		logic [8:0] meta;
		logic [8:0] lvl;
		logic [8:0] prev;
		logic [8:0] chg;
	} npio_sync_s;

	npio_sync_s st;
	npio_sync_s next_st;

	// meta is read only by lvl; edges come from lvl against prev
	always_comb begin
		next_st      = st;
		next_st.meta = pin_in;
		next_st.lvl  = st.meta;
		next_st.prev = st.lvl;
		next_st.chg  = st.lvl ^ st.prev;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level  = st.lvl;
	assign change = st.chg;

	a_level_delay: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(rst_n) && $past(rst_n, 2) |-> level == $past(pin_in, 2))
		else $error("synchronised level does not trail pin by two cycles");

endmodule

// File: rtl/npio_irq.sv
`timescale 1ns/1ps
module npio_irq (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic [8:0] flags,
	input  wire logic [8:0] status,
	input  wire logic [8:0] mask,
	input  wire logic       other_periph_irq,
	output logic            periph_irq_n,
	output logic            irq
);

	typedef struct packed {
		logic req_n;
		logic irq;
	} npio_irq_s;

	npio_irq_s st;
	npio_irq_s next_st;

	always_comb begin
		next_st       = st;
		// pending change flags and other peripheral sources share one line
		next_st.req_n = !((|flags) || other_periph_irq);
		next_st.irq   = |(status & mask);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{req_n: 1'h1, irq: 1'h0};
		end else begin
			st <= next_st;
		end
	end

	assign periph_irq_n = st.req_n;
	assign irq          = st.irq;

	a_req_held_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|flags) |=> !periph_irq_n)
		else $error("peripheral request not low while flags pending");

	a_req_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!(|flags) && !other_periph_irq) |=> periph_irq_n)
		else $error("peripheral request not released with nothing pending");

	a_req_merge: assert property (@(posedge clk_sys) disable iff (!rst_n)
		other_periph_irq |=> !periph_irq_n)
		else $error("other peripheral source not merged onto request");

	a_irq_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|(status & mask)) |=> irq)
		else $error("unmasked status bit did not raise irq");

endmodule

// File: rtl/npio_port.sv
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
// Summary of operation
// - select bit one means general io, zero alternate
// - select register resets to all ones
// - ninth line select is second data bit 1
// - direction bit zero input, one output
// - reset clears both direction registers
// - data reads pin on input, drives output
// - interrupt needs general io, input, enable
// - any edge sets flag and shared request
// - reading a flag register clears it
// - reset clears both interrupt enable registers
// - io request merged onto peripheral request line
// - request low until all flags read
module npio_port (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [15:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [8:0]  pin_in,
	output logic      [8:0]  pin_out,
	output logic      [8:0]  pin_oe_n,
	input  wire logic [8:0]  alt_out,
	input  wire logic [8:0]  alt_oe,
	output logic      [8:0]  alt_in,
	input  wire logic        other_periph_irq,
	output logic             periph_irq_n,
	output logic             irq
);

	typedef struct packed {
		logic [7:0]  sel;
		logic        sel_ninth;
		logic [8:0]  dir;
		logic [8:0]  data;
		logic [8:0]  en;
		logic [8:0]  flags;
		logic [8:0]  status;
		logic [8:0]  mask;
		logic        waitreq;
		logic [31:0] rdata;
		logic [8:0]  pin_out;
		logic [8:0]  pin_oe_n;
	} npio_state_s;

	npio_state_s st;
	npio_state_s next_st;

	logic [8:0] level;
	logic [8:0] change;
	logic [8:0] gpio_sel;
	logic [8:0] set_vec;
	logic [8:0] rd_lines;
	logic       req;
	logic       access;

	function automatic logic hit(input logic [15:0] addr, input logic [13:0] idx);
		hit = (addr[15:2] == idx);
	endfunction

	// byte lane 0 carries bits 7..0, lane 1 carries bit 8
	function automatic logic [8:0] merge9(input logic [8:0]  old,
	                                      input logic [31:0] wd,
	                                      input logic [3:0]  be);
		merge9 = {be[1] ? wd[8] : old[8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	npio_sync u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pin_in  (pin_in),
		.level   (level),
		.change  (change)
	);

	npio_irq u_irq (
		.clk_sys          (clk_sys),
		.rst_n            (rst_n),
		.flags            (st.flags),
		.status           (st.status),
		.mask             (st.mask),
		.other_periph_irq (other_periph_irq),
		.periph_irq_n     (periph_irq_n),
		.irq              (irq)
	);

	assign gpio_sel = {st.sel_ninth, st.sel};
	// a line can flag only as an enabled general io input
	assign set_vec  = change & gpio_sel & ~st.dir & st.en;
	// inputs read the pin, outputs read back the driven value
	assign rd_lines = (gpio_sel & st.dir & st.data) | (~(gpio_sel & st.dir) & level);
	assign req      = avs_read || avs_write;
	// the access completes on the edge where waitrequest is seen low
	assign access   = req && !st.waitreq;

	always_comb begin
		next_st = st;

		// one wait state: read data is sampled on the same edge that drops waitrequest
		next_st.waitreq = !(req && st.waitreq);
		if (req && st.waitreq && avs_read) begin
			next_st.rdata = 32'h0000_0000;
			if (hit(avs_address, npio_pkg::IDX_SELECT)) begin
				next_st.rdata[7:0] = st.sel;
			end else if (hit(avs_address, npio_pkg::IDX_DIR_LOW)) begin
				next_st.rdata[7:0] = st.dir[7:0];
			end else if (hit(avs_address, npio_pkg::IDX_DIR_NINTH)) begin
				next_st.rdata[0] = st.dir[8];
			end else if (hit(avs_address, npio_pkg::IDX_DATA_LOW)) begin
				next_st.rdata[7:0] = rd_lines[7:0];
			end else if (hit(avs_address, npio_pkg::IDX_DATA_NINTH)) begin
				next_st.rdata[npio_pkg::NINTH_DATA_BIT] = rd_lines[8];
				next_st.rdata[npio_pkg::NINTH_SEL_BIT]  = st.sel_ninth;
			end else if (hit(avs_address, npio_pkg::IDX_EN_LOW)) begin
				next_st.rdata[7:0] = st.en[7:0];
			end else if (hit(avs_address, npio_pkg::IDX_EN_NINTH)) begin
				next_st.rdata[0] = st.en[8];
			end else if (hit(avs_address, npio_pkg::IDX_FLAGS_LOW)) begin
				next_st.rdata[7:0] = st.flags[7:0];
			end else if (hit(avs_address, npio_pkg::IDX_FLAGS_NINTH)) begin
				next_st.rdata[0] = st.flags[8];
			end else if (hit(avs_address, npio_pkg::IDX_IRQ_STATUS)) begin
				next_st.rdata[8:0] = st.status;
			end else if (hit(avs_address, npio_pkg::IDX_IRQ_MASK)) begin
				next_st.rdata[8:0] = st.mask;
			end
		end

		// writes take effect at the completing edge
		if (access && avs_write) begin
			if (hit(avs_address, npio_pkg::IDX_SELECT) && avs_byteenable[0]) begin
				next_st.sel = avs_writedata[7:0];
			end
			if (hit(avs_address, npio_pkg::IDX_DIR_LOW) && avs_byteenable[0]) begin
				next_st.dir[7:0] = avs_writedata[7:0];
			end
			if (hit(avs_address, npio_pkg::IDX_DIR_NINTH) && avs_byteenable[0]) begin
				next_st.dir[8] = avs_writedata[0];
			end
			if (hit(avs_address, npio_pkg::IDX_DATA_LOW) && avs_byteenable[0]) begin
				next_st.data[7:0] = avs_writedata[7:0];
			end
			if (hit(avs_address, npio_pkg::IDX_DATA_NINTH) && avs_byteenable[0]) begin
				next_st.data[8]    = avs_writedata[npio_pkg::NINTH_DATA_BIT];
				next_st.sel_ninth  = avs_writedata[npio_pkg::NINTH_SEL_BIT];
			end
			if (hit(avs_address, npio_pkg::IDX_EN_LOW) && avs_byteenable[0]) begin
				next_st.en[7:0] = avs_writedata[7:0];
			end
			if (hit(avs_address, npio_pkg::IDX_EN_NINTH) && avs_byteenable[0]) begin
				next_st.en[8] = avs_writedata[0];
			end
			if (hit(avs_address, npio_pkg::IDX_IRQ_MASK)) begin
				next_st.mask = merge9(st.mask, avs_writedata, avs_byteenable);
			end
			if (hit(avs_address, npio_pkg::IDX_IRQ_STATUS)) begin
				next_st.status = st.status &
				                 ~merge9(9'h000, avs_writedata, avs_byteenable);
			end
		end

		// read clears only the bits returned, so a later edge is never lost
		if (access && avs_read && hit(avs_address, npio_pkg::IDX_FLAGS_LOW)) begin
			next_st.flags[7:0] = st.flags[7:0] & ~st.rdata[7:0];
		end
		if (access && avs_read && hit(avs_address, npio_pkg::IDX_FLAGS_NINTH)) begin
			next_st.flags[8] = st.flags[8] & ~st.rdata[0];
		end

		// new edges win over a clear in the same cycle
		next_st.flags  = next_st.flags | set_vec;
		next_st.status = next_st.status | set_vec;

		// pin drive: general io from registers, otherwise the peripheral
		next_st.pin_out  = (gpio_sel & st.data) | (~gpio_sel & alt_out);
		next_st.pin_oe_n = ~((gpio_sel & st.dir) | (~gpio_sel & alt_oe));
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st.sel       <= npio_pkg::SELECT_RESET;
			st.sel_ninth <= npio_pkg::NINTH_SEL_RESET;
			st.dir       <= npio_pkg::DIR_RESET;
			st.data      <= npio_pkg::DATA_RESET;
			st.en        <= npio_pkg::EN_RESET;
			st.flags     <= npio_pkg::FLAGS_RESET;
			st.status    <= npio_pkg::STATUS_RESET;
			st.mask      <= npio_pkg::MASK_RESET;
			st.waitreq   <= 1'h1;
			st.rdata     <= 32'h0000_0000;
			st.pin_out   <= 9'h000;
			st.pin_oe_n  <= 9'h1ff;
		end else begin
			st <= next_st;
		end
	end

	assign avs_readdata    = st.rdata;
	assign avs_waitrequest = st.waitreq;
	assign pin_out         = st.pin_out;
	assign pin_oe_n        = st.pin_oe_n;
	assign alt_in          = level;

	sequence s_req_open;
		req && avs_waitrequest;
	endsequence

	sequence s_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	sequence s_flag_read;
		avs_read && !avs_waitrequest && hit(avs_address, npio_pkg::IDX_FLAGS_LOW);
	endsequence

	a_bus_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_req_open |=> s_answer)
		else $error("bus request not answered after one wait state");

	a_reset_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(rst_n) |-> st.sel == npio_pkg::SELECT_RESET && st.sel_ninth)
		else $error("select register not all ones after reset");

	a_reset_inputs: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(rst_n) |-> st.dir == 9'h000 && pin_oe_n == 9'h1ff)
		else $error("lines not inputs after reset");

	a_reset_enables: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(rst_n) |-> st.en == 9'h000 && st.flags == 9'h000)
		else $error("interrupt enables not clear after reset");

	a_flag_on_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|set_vec) |=> (st.flags & $past(set_vec)) == $past(set_vec) ##1 !periph_irq_n)
		else $error("enabled input edge did not set flag and request");

	a_no_flag_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(change[0] && (st.dir[0] || !st.sel[0] || !st.en[0]) && !st.flags[0])
		|=> !st.flags[0])
		else $error("line flagged while not an enabled general io input");

	a_read_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_flag_read |=> (st.flags[7:0] & $past(st.rdata[7:0]) & ~$past(set_vec[7:0])) == 8'h00)
		else $error("flag register read did not clear returned bits");

	a_output_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(st.sel[0] && st.dir[0]) |=> !pin_oe_n[0] && pin_out[0] == $past(st.data[0]))
		else $error("general io output not driven from data register");

	a_alt_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!st.sel_ninth |=> pin_out[8] == $past(alt_out[8]) && pin_oe_n[8] == !$past(alt_oe[8]))
		else $error("ninth line not routed to alternate function");

endmodule

// File: verification/npio_pins.sv
`timescale 1ns/1ps
module npio_pins (
	input  wire logic [8:0] pin_out,
	input  wire logic [8:0] pin_oe_n,
	input  wire logic [8:0] ext_val,
	input  wire logic [8:0] ext_en,
	output logic      [8:0] pin_in
);
	// an undriven line falls to its pull-down, never holds the last level
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			if (!pin_oe_n[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else
				pin_in[i] = 1'b0;
		end
	end
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
	typedef struct packed {
		logic        wr;
		logic [13:0] idx;
		logic [31:0] wd;
		logic [31:0] exp;
	} npio_row_s;
	logic        clk_sys;
	logic        rst_n;
	logic [15:0] avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [8:0]  pin_in;
	logic [8:0]  pin_out;
	logic [8:0]  pin_oe_n;
	logic [8:0]  alt_out;
	logic [8:0]  alt_oe;
	logic [8:0]  alt_in;
	logic [8:0]  ext_val;
	logic [8:0]  ext_en;
	logic        other_periph_irq;
	logic        periph_irq_n;
	logic        irq;
	int          num_errors;
	int          checks_done;
	int          cycles;
	npio_row_s   rows [17];

	npio_port uut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
		.other_periph_irq(other_periph_irq), .periph_irq_n(periph_irq_n), .irq(irq));
	npio_pins pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val),
		.ext_en(ext_en), .pin_in(pin_in));

	task automatic give_verdict();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// request held until the rising edge that sees waitrequest low; data taken there
	task automatic bus(input logic wr, input logic [13:0] idx, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge clk_sys);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
		logic [31:0] rd;
		bus(1'b1, idx, wd, rd);
	endtask

	task automatic rdc(input logic [13:0] idx, input logic [31:0] exp);
		logic [31:0] rd;
		bus(1'b0, idx, 32'h0, rd);
		chk(rd, exp);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			give_verdict();
		end
	end

	initial begin
		rows = '{
			'{1'b0, npio_pkg::IDX_SELECT, 32'h0, 32'hff},
			'{1'b0, npio_pkg::IDX_DIR_LOW, 32'h0, 32'h0},
			'{1'b0, npio_pkg::IDX_DIR_NINTH, 32'h0, 32'h0},
			'{1'b0, npio_pkg::IDX_DATA_LOW, 32'h0, 32'h0},
			'{1'b0, npio_pkg::IDX_DATA_NINTH, 32'h0, 32'h2},
			'{1'b0, npio_pkg::IDX_EN_LOW, 32'h0, 32'h0},
			'{1'b0, npio_pkg::IDX_EN_NINTH, 32'h0, 32'h0},
			'{1'b0, npio_pkg::IDX_FLAGS_LOW, 32'h0, 32'h0},
			'{1'b0, npio_pkg::IDX_FLAGS_NINTH, 32'h0, 32'h0},
			'{1'b0, npio_pkg::IDX_IRQ_STATUS, 32'h0, 32'h0},
			'{1'b0, npio_pkg::IDX_IRQ_MASK, 32'h0, 32'h0},
			'{1'b1, 14'h2048, 32'h5, 32'h0},
			'{1'b1, npio_pkg::IDX_DIR_NINTH, 32'h1, 32'h1},
			'{1'b1, npio_pkg::IDX_DIR_NINTH, 32'h0, 32'h0},
			'{1'b1, npio_pkg::IDX_EN_NINTH, 32'h1, 32'h1},
			'{1'b1, npio_pkg::IDX_EN_LOW, 32'hff, 32'hff},
			'{1'b1, npio_pkg::IDX_IRQ_MASK, 32'h1ff, 32'h1ff}};
		rst_n = 1'b0;
		avs_address = 16'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		alt_out = 9'h000;
		alt_oe = 9'h000;
		ext_val = 9'h000;
		ext_en = 9'h000;
		other_periph_irq = 1'b0;
		repeat (16) @(posedge clk_sys);
		chk(32'(pin_oe_n), 32'h1ff);
		rst_n <= 1'b1;
		for (int i = 0; i < 17; i++) begin
			if (rows[i].wr)
				wr(rows[i].idx, rows[i].wd);
			rdc(rows[i].idx, rows[i].exp);
		end
		// low four lines drive, upper four and the ninth are driven from outside
		wr(npio_pkg::IDX_DIR_LOW, 32'h0f);
		wr(npio_pkg::IDX_DATA_LOW, 32'h05);
		ext_en <= 9'h1f0;
		ext_val <= 9'h1a0;
		repeat (6) @(posedge clk_sys);
		chk(32'(pin_oe_n), 32'h1f0);
		chk(32'(pin_out[3:0]), 32'h5);
		rdc(npio_pkg::IDX_DATA_LOW, 32'ha5);
		chk(32'(periph_irq_n), 32'h0);
		wr(npio_pkg::IDX_DATA_LOW, 32'h0a);
		repeat (6) @(posedge clk_sys);
		rdc(npio_pkg::IDX_FLAGS_LOW, 32'ha0);
		rdc(npio_pkg::IDX_FLAGS_LOW, 32'h0);
		chk(32'(periph_irq_n), 32'h0);
		rdc(npio_pkg::IDX_FLAGS_NINTH, 32'h1);
		repeat (3) @(posedge clk_sys);
		chk(32'(periph_irq_n), 32'h1);
		chk(32'(irq), 32'h1);
		wr(npio_pkg::IDX_IRQ_MASK, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk(32'(irq), 32'h0);
		wr(npio_pkg::IDX_IRQ_MASK, 32'h1ff);
		rdc(npio_pkg::IDX_IRQ_STATUS, 32'h1a0);
		wr(npio_pkg::IDX_IRQ_STATUS, 32'h1a0);
		repeat (2) @(posedge clk_sys);
		chk(32'(irq), 32'h0);
		// serial use keeps the frame sync and data lines on the alternate side
		alt_oe <= 9'h101;
		alt_out <= 9'h101;
		wr(npio_pkg::IDX_SELECT, 32'hd8);
		repeat (3) @(posedge clk_sys);
		chk(32'(pin_oe_n[3:0]), 32'h6);
		chk(32'(pin_out[0]), 32'h1);
		chk(32'(pin_oe_n[8]), 32'h1);
		chk(32'(alt_in[5]), 32'h1);
		ext_val <= 9'h180;
		wr(npio_pkg::IDX_DATA_NINTH, 32'h0);
		repeat (6) @(posedge clk_sys);
		chk(32'(alt_in[5]), 32'h0);
		chk(32'({pin_oe_n[8], pin_out[8]}), 32'h1);
		rdc(npio_pkg::IDX_FLAGS_LOW, 32'h0);
		other_periph_irq <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk(32'(periph_irq_n), 32'h0);
		other_periph_irq <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(32'(periph_irq_n), 32'h1);
		// second reset in mid-run must restore the power-up configuration
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(32'(pin_oe_n), 32'h1ff);
		rst_n <= 1'b1;
		rdc(npio_pkg::IDX_SELECT, 32'hff);
		rdc(npio_pkg::IDX_DIR_LOW, 32'h0);
		rdc(npio_pkg::IDX_EN_LOW, 32'h0);
		// an 8-bit register ignores a write without byte lane 0
		avs_byteenable <= 4'he;
		wr(npio_pkg::IDX_DIR_LOW, 32'hff);
		avs_byteenable <= 4'hf;
		rdc(npio_pkg::IDX_DIR_LOW, 32'h0);
		give_verdict();
	end
endmodule
